// ==== rtl/vpls_map.svh ====
// Register offsets, field positions, reset values and timing for the valve supervisor
`ifndef VPLS_MAP_SVH
`define VPLS_MAP_SVH

// Byte offsets, all on the AHB-Lite slave
`define VPLS_A_TARGET    8'h00
`define VPLS_A_MOT_TH    8'h04
`define VPLS_A_STB_TH    8'h08
`define VPLS_A_SEAT_TH   8'h0c
`define VPLS_A_BACK_TH   8'h10
`define VPLS_A_FLT_TH    8'h14
`define VPLS_A_PERSIST   8'h18
`define VPLS_A_CAL_FULL  8'h1c
`define VPLS_A_CAL_ZERO  8'h20
`define VPLS_A_FB_GAIN   8'h24
`define VPLS_A_FAST_GAIN 8'h28
`define VPLS_A_SOFT_GAIN 8'h2c
`define VPLS_A_STATUS    8'h30
`define VPLS_A_IRQ_STAT  8'h34
`define VPLS_A_IRQ_MASK  8'h38
`define VPLS_A_POSITION  8'h3c

// Reset values; positions and gains in hundredths
`define VPLS_RST_TARGET  16'h0000
`define VPLS_RST_MOT_TH  16'h0064
`define VPLS_RST_STB_TH  16'h0014
`define VPLS_RST_SEAT_TH 16'h0000
`define VPLS_RST_BACK_TH 16'h2710
`define VPLS_RST_FLT_TH  16'h03e8
`define VPLS_PERSIST_MS  16'h2710
`define VPLS_RST_CAL_FUL 16'h7530
`define VPLS_RST_CAL_ZER 16'h8ad0
`define VPLS_RST_FB_GAIN 16'h0800
`define VPLS_RST_FAST_G  16'h0398
`define VPLS_RST_SOFT_G  16'h008c
`define VPLS_FB_WORD_MAX 16'h0fff

// Full scale of the position in hundredths of a percent
`define VPLS_POS_SCALE   32'sh0000_2710

// Status bits
`define VPLS_ST_FAST     0
`define VPLS_ST_SEAT     1
`define VPLS_ST_BACK     2
`define VPLS_ST_CAND     3
`define VPLS_ST_FAULT    4
`define VPLS_ST_SHUTDN   5
`define VPLS_ST_FORCED   6

// Interrupt bits
`define VPLS_IRQ_FAULT   0
`define VPLS_IRQ_SEAT    1
`define VPLS_IRQ_BACK    2

// Timing: one millisecond at the 125 MHz clock
`define VPLS_CLK_MHZ     125
`define VPLS_MS_US       1000
`define VPLS_MS_CYCLES   (`VPLS_MS_US * `VPLS_CLK_MHZ)

`endif

// ==== rtl/vpls_pkg.sv ====
// Types shared by the valve supervisor files
package vpls_pkg;
    typedef logic signed [15:0] vpls_pos_t;
    typedef enum logic [1:0] {
        VPLS_CV_IDLE = 2'b00,
        VPLS_CV_RUN  = 2'b01,
        VPLS_CV_DONE = 2'b10
    } vpls_cvt_e;
endpackage

// ==== rtl/vpls_pos_conv.sv ====
// Converts an A/D feedback reading to position by calibration interpolation
`timescale 1ns/1ps
`include "vpls_map.svh"
module vpls_pos_conv (
    // Clock and reset
    input  wire logic          hclk,
    input  wire logic          hresetn,
    // Feedback sample
    input  wire logic signed [15:0] adc_data,
    input  wire logic          adc_valid,
    // Calibration
    input  wire logic signed [15:0] cal_zero,
    input  wire logic signed [15:0] cal_full,
    // Result
    output vpls_pkg::vpls_pos_t pos,
    output logic               pos_valid
);
    vpls_pkg::vpls_cvt_e st_r;
    logic [31:0] num_r;
    logic [16:0] den_r;
    logic [17:0] rem_r;
    logic [4:0]  cnt_r;
    logic        neg_r;

    ////////////////////////////////////////////////////////////
    // Numerator and span, pos = (adc-zero)*scale/(full-zero)
    wire signed [16:0] diff = 17'(adc_data) - 17'(cal_zero);
    wire signed [16:0] span = 17'(cal_full) - 17'(cal_zero);
    wire signed [31:0] prod = 32'(diff) * `VPLS_POS_SCALE;
    wire [31:0] prod_mag = prod[31] ? 32'(-prod) : prod;
    wire [16:0] span_mag = span[16] ? 17'(-span) : span;
    // Zero span cannot be divided; such samples are dropped
    wire go = (st_r == vpls_pkg::VPLS_CV_IDLE) && adc_valid && (span != 17'sh0);
    wire [17:0] rem_sh = {rem_r[16:0], num_r[31]};
    wire rem_ge = rem_sh >= {1'b0, den_r};
    wire [15:0] mag_sat = (|num_r[31:15]) ? 16'h7fff : num_r[15:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r      <= vpls_pkg::VPLS_CV_IDLE;
            num_r     <= 32'h0;
            den_r     <= 17'h0;
            rem_r     <= 18'h0;
            cnt_r     <= 5'h0;
            neg_r     <= 1'b0;
            pos       <= 16'sh0;
            pos_valid <= 1'b0;
        end else begin
            pos_valid <= 1'b0;
            unique case (st_r)
                vpls_pkg::VPLS_CV_IDLE: begin
                    if (go) begin
                        num_r <= prod_mag;
                        den_r <= span_mag;
                        rem_r <= 18'h0;
                        cnt_r <= 5'h0;
                        neg_r <= prod[31] ^ span[16];
                        st_r  <= vpls_pkg::VPLS_CV_RUN;
                    end
                end
                vpls_pkg::VPLS_CV_RUN: begin
                    num_r <= {num_r[30:0], rem_ge};
                    rem_r <= rem_ge ? 18'(rem_sh - {1'b0, den_r}) : rem_sh;
                    cnt_r <= 5'(cnt_r + 5'h1);
                    if (cnt_r == 5'h1f) begin
                        st_r <= vpls_pkg::VPLS_CV_DONE;
                    end
                end
                vpls_pkg::VPLS_CV_DONE: begin
                    pos       <= neg_r ? 16'(-mag_sat) : mag_sat;
                    pos_valid <= 1'b1;
                    st_r      <= vpls_pkg::VPLS_CV_IDLE;
                end
                default: st_r <= vpls_pkg::VPLS_CV_IDLE;
            endcase
        end
    end
endmodule

// ==== rtl/vpls_supervisor.sv ====
// Valve position loop supervisor with AHB-Lite register slave
//
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "vpls_map.svh"
// Summary of operation
// - Error above motion threshold selects fast tuning
// - Error below stable threshold selects soft tuning
// - Target at/below seat threshold drives seating
// - Target at/above backseat threshold drives backseating
// - Error above fault threshold flags a candidate
// - Report only after unbroken persistence time
// - Shutdown-forced target at zero position: no report
// - Hold writable full-scale calibration, default 30000
// - Hold writable zero calibration, default -30000
// - DAC gain equals 4096 over the word
// - DAC gain word accepted up to fff, larger words saturate; fast and soft gain words take the full 16 bits
// - Fast gain 9.20 moving, soft gain 1.40 stable
module vpls_supervisor #(
    parameter int unsigned CYC_PER_MS = `VPLS_MS_CYCLES,
    parameter logic [15:0] PERSIST_MS = `VPLS_PERSIST_MS
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Feedback A/D, same clock
    input  wire logic signed [15:0] adc_data,
    input  wire logic        adc_valid,
    // Plant pin
    input  wire logic        shutdown_in,
    // Loop control outputs
    output logic             pi_enable,
    output logic             seat_drive,
    output logic             backseat_drive,
    output logic             fast_mode,
    output logic [15:0]      loop_gain,
    output logic [11:0]      fb_gain_dac,
    // Upstream report and interrupt
    output logic             fault_report,
    output logic             irq
);
    localparam int NCFG = 12;
    localparam int MSW  = $clog2(CYC_PER_MS + 1);

    ////////////////////////////////////////////////////////////
    // Register reset values
    function automatic logic [15:0] cfg_rst(input logic [3:0] ix);
        case (ix)
            4'(`VPLS_A_MOT_TH >> 2):    cfg_rst = `VPLS_RST_MOT_TH;
            4'(`VPLS_A_STB_TH >> 2):    cfg_rst = `VPLS_RST_STB_TH;
            4'(`VPLS_A_SEAT_TH >> 2):   cfg_rst = `VPLS_RST_SEAT_TH;
            4'(`VPLS_A_BACK_TH >> 2):   cfg_rst = `VPLS_RST_BACK_TH;
            4'(`VPLS_A_FLT_TH >> 2):    cfg_rst = `VPLS_RST_FLT_TH;
            4'(`VPLS_A_PERSIST >> 2):   cfg_rst = PERSIST_MS;
            4'(`VPLS_A_CAL_FULL >> 2):  cfg_rst = `VPLS_RST_CAL_FUL;
            4'(`VPLS_A_CAL_ZERO >> 2):  cfg_rst = `VPLS_RST_CAL_ZER;
            4'(`VPLS_A_FB_GAIN >> 2):   cfg_rst = `VPLS_RST_FB_GAIN;
            4'(`VPLS_A_FAST_GAIN >> 2): cfg_rst = `VPLS_RST_FAST_G;
            4'(`VPLS_A_SOFT_GAIN >> 2): cfg_rst = `VPLS_RST_SOFT_G;
            default:                cfg_rst = `VPLS_RST_TARGET;
        endcase
    endfunction

    function automatic logic [3:0] ix_of(input logic [7:0] a);
        ix_of = a[5:2];
    endfunction

    ////////////////////////////////////////////////////////////
    // AHB-Lite address and data phase
    logic [15:0] cfg_r [NCFG];
    logic        dp_wr_r;
    logic [7:0]  dp_addr_r;
    logic [31:0] hrdata_r;
    logic [2:0]  irq_stat_r;
    logic [2:0]  irq_mask_r;

    wire ap      = hsel & hready & htrans[1];
    wire [3:0] wr_ix = ix_of(dp_addr_r);
    wire wr_map  = dp_wr_r && (dp_addr_r[7:6] == 2'b00);
    wire wr_cfg  = wr_map && (wr_ix < 4'hc);
    wire [15:0] wdat = hwdata[15:0];
    wire wr_fb   = wr_map && (wr_ix == ix_of(`VPLS_A_FB_GAIN));
    // Words past the DAC range saturate like the DAC itself
    wire [15:0] wdat_cfg = (wr_fb && wdat > `VPLS_FB_WORD_MAX) ? `VPLS_FB_WORD_MAX : wdat;
    wire wr_istat = wr_map && (wr_ix == ix_of(`VPLS_A_IRQ_STAT));
    wire wr_imask = wr_map && (wr_ix == ix_of(`VPLS_A_IRQ_MASK));

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_r   <= 1'b0;
            dp_addr_r <= 8'h00;
        end else begin
            dp_wr_r   <= ap & hwrite;
            dp_addr_r <= ap ? haddr[7:0] : dp_addr_r;
        end
    end

    for (genvar i = 0; i < NCFG; i++) begin : g_cfg
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                cfg_r[i] <= cfg_rst(4'(i));
            end else if (wr_cfg && wr_ix == 4'(i)) begin
                cfg_r[i] <= wdat_cfg;
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // Named configuration fields
    wire signed [15:0] tgt_up   = cfg_r[ix_of(`VPLS_A_TARGET)];
    wire [16:0] th_mot          = {1'b0, cfg_r[ix_of(`VPLS_A_MOT_TH)]};
    wire [16:0] th_stb          = {1'b0, cfg_r[ix_of(`VPLS_A_STB_TH)]};
    wire signed [15:0] th_seat  = cfg_r[ix_of(`VPLS_A_SEAT_TH)];
    wire signed [15:0] th_back  = cfg_r[ix_of(`VPLS_A_BACK_TH)];
    wire [16:0] th_flt          = {1'b0, cfg_r[ix_of(`VPLS_A_FLT_TH)]};
    wire [15:0] persist_ms      = cfg_r[ix_of(`VPLS_A_PERSIST)];
    wire signed [15:0] cal_full = cfg_r[ix_of(`VPLS_A_CAL_FULL)];
    wire signed [15:0] cal_zero = cfg_r[ix_of(`VPLS_A_CAL_ZERO)];
    wire [15:0] fast_gain       = cfg_r[ix_of(`VPLS_A_FAST_GAIN)];
    wire [15:0] soft_gain       = cfg_r[ix_of(`VPLS_A_SOFT_GAIN)];

    ////////////////////////////////////////////////////////////
    // Shutdown pin synchroniser
    logic sd_s1_r;
    logic sd_s2_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sd_s1_r <= 1'b0;
            sd_s2_r <= 1'b0;
        end else begin
            sd_s1_r <= shutdown_in;
            sd_s2_r <= sd_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////
    // Measured position
    vpls_pkg::vpls_pos_t pos_meas;

    vpls_pos_conv u_conv (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .adc_data  (adc_data),
        .adc_valid (adc_valid),
        .cal_zero  (cal_zero),
        .cal_full  (cal_full),
        .pos       (pos_meas),
        .pos_valid ()
    );

    ////////////////////////////////////////////////////////////
    // Target and error
    // Shutdown forces the local target to zero
    wire signed [15:0] tgt_eff = sd_s2_r ? 16'sh0 : tgt_up;
    wire forced = sd_s2_r && (tgt_up != 16'sh0);
    wire signed [16:0] err = 17'(tgt_eff) - 17'(pos_meas);
    wire [16:0] abs_err = err[16] ? 17'(-err) : err;

    ////////////////////////////////////////////////////////////
    // Tuning selection with hysteresis
    logic fast_r;
    wire over_mot  = abs_err > th_mot;
    wire under_stb = abs_err < th_stb;
    wire fast_nxt  = over_mot ? 1'b1 :
                     under_stb ? 1'b0 :
                     fast_r;

    // Seating wins if both limits overlap
    wire seat_c = tgt_eff <= th_seat;
    wire back_c = !seat_c && (tgt_eff >= th_back);

    logic seat_r;
    logic back_r;
    logic pi_en_r;
    logic [15:0] gain_r;
    logic [11:0] dac_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fast_r  <= 1'b0;
            seat_r  <= 1'b0;
            back_r  <= 1'b0;
            pi_en_r <= 1'b0;
            gain_r  <= `VPLS_RST_SOFT_G;
            dac_r   <= 12'(`VPLS_RST_FB_GAIN);
        end else begin
            fast_r  <= fast_nxt;
            seat_r  <= seat_c;
            back_r  <= back_c;
            pi_en_r <= !seat_c && !back_c;
            gain_r  <= fast_nxt ? fast_gain : soft_gain;
            dac_r   <= cfg_r[ix_of(`VPLS_A_FB_GAIN)][11:0];
        end
    end

    assign fast_mode      = fast_r;
    assign seat_drive     = seat_r;
    assign backseat_drive = back_r;
    assign pi_enable      = pi_en_r;
    assign loop_gain      = gain_r;
    assign fb_gain_dac    = dac_r;

    ////////////////////////////////////////////////////////////
    // Contingency detection and persistence
    // Shutdown-forced zero target is not a fault once seated
    wire shut_ok = forced && (pos_meas <= 16'sh0);
    wire cand = (abs_err > th_flt) && !shut_ok;

    logic [MSW-1:0] ms_cnt_r;
    logic [15:0]    per_cnt_r;
    logic           fault_r;
    wire ms_tick = ms_cnt_r == MSW'(CYC_PER_MS - 1);
    wire fault_nxt = cand && (per_cnt_r >= persist_ms);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ms_cnt_r  <= '0;
            per_cnt_r <= 16'h0;
            fault_r   <= 1'b0;
        end else begin
            fault_r <= fault_nxt;
            if (!cand) begin
                ms_cnt_r  <= '0;
                per_cnt_r <= 16'h0;
            end else if (ms_tick) begin
                ms_cnt_r <= '0;
                if (per_cnt_r != 16'hffff) begin
                    per_cnt_r <= 16'(per_cnt_r + 16'h1);
                end
            end else begin
                ms_cnt_r <= MSW'(ms_cnt_r + 1'b1);
            end
        end
    end

    assign fault_report = fault_r;

    ////////////////////////////////////////////////////////////
    // Interrupts: rising events, write one to clear
    wire [2:0] irq_ev = {back_c & ~back_r, seat_c & ~seat_r, fault_nxt & ~fault_r};
    wire [2:0] irq_clr = wr_istat ? wdat[2:0] : 3'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_r <= 3'h0;
            irq_mask_r <= 3'h0;
        end else begin
            // New event beats a clear in the same cycle
            irq_stat_r <= irq_ev | (irq_stat_r & ~irq_clr);
            irq_mask_r <= wr_imask ? wdat[2:0] : irq_mask_r;
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    ////////////////////////////////////////////////////////////
    // Read data, registered in the address phase
    wire [3:0] rd_ix = ix_of(haddr[7:0]);
    wire [15:0] status = {9'h0, forced, sd_s2_r, fault_r, cand, back_r, seat_r, fast_r};
    // A configuration register write still in its data phase is forwarded
    wire fwd = wr_cfg && (wr_ix == rd_ix);
    wire [15:0] rd_cfg = fwd ? wdat_cfg : cfg_r[rd_ix];
    wire [15:0] rd_word =
        (rd_ix == ix_of(`VPLS_A_STATUS))   ? status :
        (rd_ix == ix_of(`VPLS_A_IRQ_STAT)) ? {13'h0, irq_stat_r} :
        (rd_ix == ix_of(`VPLS_A_IRQ_MASK)) ? {13'h0, irq_mask_r} :
        (rd_ix == ix_of(`VPLS_A_POSITION)) ? pos_meas :
        rd_cfg;
    wire rd_map = haddr[7:6] == 2'b00;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0;
        end else if (ap && !hwrite) begin
            hrdata_r <= rd_map ? {16'h0, rd_word} : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////
    // Checks
    a_fast_select: assert property (
        @(posedge hclk) disable iff (!hresetn)
        over_mot |=> fast_mode && loop_gain == $past(fast_gain)
    ) else $error("fast tuning not taken");

    a_soft_select: assert property (
        @(posedge hclk) disable iff (!hresetn)
        under_stb && !over_mot |=> !fast_mode
    ) else $error("soft tuning not taken");

    a_band_hold: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !under_stb && !over_mot |=> fast_mode == $past(fast_mode)
    ) else $error("tuning changed inside band");

    a_seat_drive: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (tgt_eff <= th_seat) |=> seat_drive && !pi_enable && !backseat_drive
    ) else $error("seating not in control");

    a_backseat_drive: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (tgt_eff > th_seat) && (tgt_eff >= th_back) |=> backseat_drive && !pi_enable
    ) else $error("backseating not in control");

    a_fault_quiet: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !cand |=> !fault_report ##1 (per_cnt_r <= 16'h1)
    ) else $error("fault without candidate");

    a_fault_persist: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(fault_report) |-> $past(cand) && $past(per_cnt_r) >= $past(persist_ms)
    ) else $error("fault before persistence time");

    a_shutdown_mask: assert property (
        @(posedge hclk) disable iff (!hresetn)
        sd_s2_r && tgt_up != 16'sh0 && pos_meas <= 16'sh0 |=> !fault_report
    ) else $error("fault while shut down at zero");

    a_gain_soft: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !fast_mode |-> loop_gain == $past(soft_gain)
    ) else $error("soft gain not applied");

    a_dac_range: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_fb && wdat > `VPLS_FB_WORD_MAX |=> ##1 fb_gain_dac == 12'hfff
    ) else $error("gain word not saturated");

    a_irq_level: assert property (
        @(posedge hclk) disable iff (!hresetn)
        irq_ev[`VPLS_IRQ_FAULT] && irq_mask_r[`VPLS_IRQ_FAULT] && !wr_imask |=> irq
    ) else $error("interrupt not raised");
endmodule

// ==== bench/vpls_valve_model.sv ====
// Valve actuator model: LVDT feedback sampled by the A/D converter
`timescale 1ns/1ps
module vpls_valve_model #(
    parameter int PERIOD = 40
) (
    // Clock and reset
    input  wire logic               hclk,
    input  wire logic               hresetn,
    // Reading the valve gives now
    input  wire logic signed [15:0] reading,
    // A/D sample to the supervisor
    output logic signed [15:0]      adc_data,
    output logic                    adc_valid
);
    int cnt;

    // Spacing above the 34-cycle conversion, so no sample is dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 0;
            adc_valid <= 1'b0;
            adc_data <= 16'h0000;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            adc_valid <= (cnt == 0);
            // Data only good with the strobe; scrambled otherwise
            adc_data <= (cnt == 0) ? reading : ~reading;
        end
    end
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the valve position loop supervisor
`timescale 1ns/1ps
`include "vpls_map.svh"
module testbench;
    logic               hclk, hresetn, hwrite, hready, shutdown_in;
    logic [1:0]         htrans;
    logic [31:0]        haddr, hwdata, hrdata, rd;
    logic               hreadyout, hresp, adc_valid, pi_enable, seat_drive;
    logic               backseat_drive, fast_mode, fault_report, irq;
    logic signed [15:0] adc_data, reading;
    logic [15:0]        loop_gain;
    logic [11:0]        fb_gain_dac;
    int                 error_cnt, total_checks;

    assign hready = hreadyout;

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // Short millisecond keeps the persistence run brief
    vpls_supervisor #(.CYC_PER_MS(4), .PERSIST_MS(16'h0005)) vpls_supervisor_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .adc_data(adc_data), .adc_valid(adc_valid),
        .shutdown_in(shutdown_in), .pi_enable(pi_enable), .seat_drive(seat_drive),
        .backseat_drive(backseat_drive), .fast_mode(fast_mode), .loop_gain(loop_gain),
        .fb_gain_dac(fb_gain_dac), .fault_report(fault_report), .irq(irq));

    vpls_valve_model vpls_valve_model_inst (
        .hclk(hclk), .hresetn(hresetn), .reading(reading), .adc_data(adc_data), .adc_valid(adc_valid));

    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic wait_hr;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            error_cnt++;
            $display("Error hready expected 1 seen %b", hready);
            close_out();
        end
    endtask

    // One single word transfer; read data taken at the data phase edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= w;
        wait_hr();
        htrans <= 2'b00;
        hwdata <= d;
        wait_hr();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        chk(nm, e, rd);
    endtask

    // Over two sample periods so the newest reading is converted
    task automatic set_rd(input logic signed [15:0] v);
        reading <= v;
        tick(90);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        tick(1);
        chk("seat_drive", 32'h1, seat_drive);
        chk("pi_enable", 32'h0, pi_enable);
        chk("hresp", 32'h0, hresp);
        rchk("cal_full", `VPLS_A_CAL_FULL, 32'h00007530);
        rchk("cal_zero", `VPLS_A_CAL_ZERO, 32'h00008ad0);
        rchk("fast_gain", `VPLS_A_FAST_GAIN, 32'h00000398);
        rchk("soft_gain", `VPLS_A_SOFT_GAIN, 32'h0000008c);
        rchk("fb_word", `VPLS_A_FB_GAIN, 32'h00000800);
        rchk("unmapped", 8'h40, 32'h00000000);
    endtask

    task automatic t_conv;
        wr(`VPLS_A_CAL_ZERO, 32'h00000000);
        wr(`VPLS_A_CAL_FULL, 32'h00000003);
        set_rd(16'sh0001);
        rchk("position", `VPLS_A_POSITION, 32'h00000d05);
        wr(`VPLS_A_CAL_ZERO, 32'h00008ad0);
        wr(`VPLS_A_CAL_FULL, 32'h00007530);
        set_rd(16'sh0000);
        rchk("position", `VPLS_A_POSITION, 32'h00001388);
    endtask

    // Walk the hysteresis band from both sides, boundaries included
    task automatic t_tune;
        logic [15:0] tg[7] = '{16'h1388, 16'h141e, 16'h13ba, 16'h1374, 16'h1392, 16'h13ec, 16'h1310};
        logic        fm[7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        for (int i = 0; i < 7; i++) begin
            wr(`VPLS_A_TARGET, {16'h0000, tg[i]});
            tick(3);
            chk("fast_mode", {31'h0, fm[i]}, fast_mode);
            chk("loop_gain", fm[i] ? 32'h398 : 32'h8c, loop_gain);
            chk("pi_enable", 32'h1, pi_enable);
        end
    endtask

    task automatic t_limits;
        wr(`VPLS_A_IRQ_STAT, 32'h00000007);
        wr(`VPLS_A_TARGET, 32'h00002710);
        tick(3);
        chk("backseat_drive", 32'h1, backseat_drive);
        chk("pi_enable", 32'h0, pi_enable);
        rchk("irq_status", `VPLS_A_IRQ_STAT, 32'h00000004);
        wr(`VPLS_A_TARGET, 32'h0000270f);
        tick(3);
        chk("backseat_drive", 32'h0, backseat_drive);
        wr(`VPLS_A_SEAT_TH, 32'h00000064);
        wr(`VPLS_A_TARGET, 32'h00000064);
        tick(3);
        chk("seat_drive", 32'h1, seat_drive);
        wr(`VPLS_A_TARGET, 32'h00000065);
        tick(3);
        chk("seat_drive", 32'h0, seat_drive);
        wr(`VPLS_A_SEAT_TH, 32'h00000000);
        // Back on the valve, so the limit moves leave no running candidate
        wr(`VPLS_A_TARGET, 32'h00001388);
        tick(2);
    endtask

    // Interrupted candidate first, so an unreset timer would report early
    task automatic t_fault;
        int n;
        wr(`VPLS_A_IRQ_STAT, 32'h00000007);
        wr(`VPLS_A_IRQ_MASK, 32'h00000001);
        wr(`VPLS_A_TARGET, 32'h000017d4);
        tick(10);
        rchk("status", `VPLS_A_STATUS, 32'h00000009);
        chk("fault_report", 32'h0, fault_report);
        wr(`VPLS_A_TARGET, 32'h00001388);
        tick(2);
        wr(`VPLS_A_TARGET, 32'h000017d4);
        tick(12);
        chk("fault_report", 32'h0, fault_report);
        n = 0;
        while (fault_report !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        chk("fault_report", 32'h1, fault_report);
        chk("irq", 32'h1, irq);
        wr(`VPLS_A_IRQ_STAT, 32'h00000001);
        tick(1);
        chk("irq", 32'h0, irq);
        wr(`VPLS_A_IRQ_MASK, 32'h00000000);
        wr(`VPLS_A_TARGET, 32'h00001388);
        tick(3);
        chk("fault_report", 32'h0, fault_report);
    endtask

    task automatic t_gain;
        wr(`VPLS_A_FB_GAIN, 32'h00000100);
        tick(3);
        chk("fb_gain_dac", 32'h100, fb_gain_dac);
        wr(`VPLS_A_FB_GAIN, 32'h00000fff);
        tick(3);
        chk("fb_gain_dac", 32'hfff, fb_gain_dac);
        wr(`VPLS_A_FB_GAIN, 32'h00001234);
        rchk("fb_word", `VPLS_A_FB_GAIN, 32'h00000fff);
    endtask

    // Position settles slightly below zero with a low fault limit
    task automatic t_shut;
        wr(`VPLS_A_PERSIST, 32'h000003e8);
        wr(`VPLS_A_FLT_TH, 32'h00000064);
        shutdown_in <= 1'b1;
        set_rd(-16'sd31000);
        wr(`VPLS_A_PERSIST, 32'h00000005);
        tick(40);
        chk("seat_drive", 32'h1, seat_drive);
        chk("fault_report", 32'h0, fault_report);
        rchk("status", `VPLS_A_STATUS, 32'h00000063);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        hresetn = 1'b0;
        htrans = 2'b00;
        haddr = 32'h00000000;
        hwrite = 1'b0;
        hwdata = 32'h00000000;
        shutdown_in = 1'b0;
        reading = 16'sh0000;
        error_cnt = 0;
        total_checks = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_conv();
        t_tune();
        t_limits();
        t_fault();
        t_gain();
        t_shut();
        close_out();
    end
endmodule
